// ===== include/status_pkg.sv
// Shared constants and command codes for the status-reporting register set
package status_pkg;
  localparam int REG_W            = 16;
  localparam int BYTE_W           = 8;
  localparam int OPER_SETTLED_BIT = 8;
  localparam int QUES_DCV_BIT     = 0;
  localparam int QUES_TEMP_BIT    = 4;
  localparam int QUES_OHMS_BIT    = 9;
  localparam int ESR_OPC_BIT      = 0;
  localparam int ESR_QUERY_BIT    = 2;
  localparam int ESR_DEV_BIT      = 3;
  localparam int ESR_EXEC_BIT     = 4;
  localparam int ESR_CMD_BIT      = 5;
  localparam int ESR_PON_BIT      = 7;
  localparam int STB_ERRQ_BIT     = 2;
  localparam int STB_QUES_BIT     = 3;
  localparam int STB_ESR_BIT      = 5;
  localparam int STB_RQS_BIT      = 6;
  localparam int STB_OPER_BIT     = 7;
  localparam int ERRQ_DEPTH       = 20;
  localparam int ERRQ_PTR_W       = 5;
  localparam int ERR_W            = 16;
  localparam logic [ERRQ_PTR_W-1:0] ERRQ_LAST  = 5'h13;
  localparam logic [ERRQ_PTR_W-1:0] ERRQ_FULL  = 5'h14;
  localparam logic [REG_W-1:0]      RESP_ONE   = 16'h0001;
  localparam logic [REG_W-1:0]      REG_RESET  = 16'h0000;
  localparam logic [BYTE_W-1:0]     BYTE_RESET = 8'h00;

  typedef enum logic [4:0] {
    CMD_NOP, CMD_CLS, CMD_STAT_PRESET,
    CMD_QUES_COND_Q, CMD_QUES_EVENT_Q, CMD_QUES_EN_W, CMD_QUES_EN_Q,
    CMD_OPER_COND_Q, CMD_OPER_EVENT_Q, CMD_OPER_EN_W, CMD_OPER_EN_Q,
    CMD_ESE_W, CMD_ESE_Q, CMD_ESR_Q, CMD_OPC, CMD_OPC_Q,
    CMD_PSC_W, CMD_PSC_Q, CMD_SRE_W, CMD_SRE_Q, CMD_ERR_Q
  } cmd_e;
endpackage

// ===== include/errq_if.sv
// Link between the register set and its error queue
`timescale 1ns/1ps
interface errq_if;
  logic                          push;
  logic [status_pkg::ERR_W-1:0]  push_code;
  logic                          pop;
  logic [status_pkg::ERR_W-1:0]  head;
  logic                          empty;
  logic [status_pkg::ERRQ_PTR_W-1:0] count;
  modport owner (output push, push_code, pop, input head, empty, count);
  modport queue (input push, push_code, pop, output head, empty, count);
endinterface

// ===== verilog/error_queue.sv
// First-in first-out store of error codes
`timescale 1ns/1ps
module error_queue (
  input wire logic mclk,
  input wire logic sys_rst,
  errq_if.queue    q
);
  typedef struct packed {
    logic [status_pkg::ERRQ_DEPTH-1:0][status_pkg::ERR_W-1:0] mem;
    logic [status_pkg::ERRQ_PTR_W-1:0]                        rd;
    logic [status_pkg::ERRQ_PTR_W-1:0]                        wr;
    logic [status_pkg::ERRQ_PTR_W-1:0]                        count;
  } errq_s;

  errq_s s_q;
  errq_s s_d;
  logic  do_pop;
  logic  do_push;

  assign q.head  = s_q.mem[s_q.rd];
  assign q.empty = (s_q.count == '0);
  assign q.count = s_q.count;

  always_comb
  begin
    s_d     = s_q;
    do_pop  = q.pop && (s_q.count != '0);
    // A full queue drops the newest error so the oldest ones survive
    do_push = q.push && ((s_q.count != status_pkg::ERRQ_FULL) || do_pop);
    if (do_pop)
    begin
      s_d.rd = (s_q.rd == status_pkg::ERRQ_LAST) ? '0 : s_q.rd + 5'h01;
    end
    if (do_push)
    begin
      s_d.mem[s_q.wr] = q.push_code;
      s_d.wr = (s_q.wr == status_pkg::ERRQ_LAST) ? '0 : s_q.wr + 5'h01;
    end
    s_d.count = s_q.count + {4'h0, do_push} - {4'h0, do_pop};
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_errq_bound;
    s_q.count <= status_pkg::ERRQ_FULL;
  endproperty
  a_errq_bound: assert property (p_errq_bound) else $error("error queue over 20 entries"); // [R8]

  property p_errq_fifo;
    (q.pop && !q.empty && !q.push) |=> (s_q.count == $past(s_q.count) - 5'h01);
  endproperty
  a_errq_fifo: assert property (p_errq_fifo) else $error("pop did not remove one entry"); // [R8]
endmodule

// ===== verilog/status_regs.sv
// Status-reporting register set with command port and error queue
//
// Behaviour
// R1: Questionable event register clears on clear-status and on its own query.
// R2: Questionable enable clears at power-on, on preset, and on write of 0.
// R3: Each 0-to-1 change of an operational condition bit latches into its event bit.
// R4: Only operational bit 8 is used: filter enabled and settled; rest read 0.
// R5: Settled condition updates every measurement; event bit records ever settled.
// R6: Operational event register clears on clear-status and on its own query.
// R7: Operational enable clears at power-on, on preset, and on write of 0.
// R8: Error queue holds 20 entries, returned oldest first on each error query.
// R9: Every register query answers with the binary-weighted value of set bits.
// R10: Written enable masks are stored and select event bits for the status byte.
// R11: Preset clears questionable and operational enables, nothing else.
// R12: Clear-status clears the status byte summary and every event register; the code keeps the error queue and its status byte bit 2.
// R13: Operation-complete command sets standard event bit 0 after earlier commands.
// R14: Operation-complete query puts response 1 in the output buffer.
// R15: Non-volatile power-on-clear flag decides if status and event enables clear.
// R16: Questionable bits 0, 4, 9 flag volt, temperature, ohms overload; others 0.
// R17: Each status byte summary bit is OR of event AND enable.
`timescale 1ns/1ps
module status_regs (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        cmd_valid,
  input  wire logic [4:0]  cmd_code,
  input  wire logic [15:0] cmd_data,
  input  wire logic        meas_done,
  input  wire logic        filter_enabled,
  input  wire logic        filter_settled,
  input  wire logic        ovld_dcv,
  input  wire logic        ovld_temp,
  input  wire logic        ovld_ohms,
  input  wire logic        err_query,
  input  wire logic        err_device,
  input  wire logic        err_exec,
  input  wire logic        err_command,
  input  wire logic        err_push,
  input  wire logic [15:0] err_code,
  input  wire logic        nv_psc,
  input  wire logic [7:0]  nv_ese,
  input  wire logic [7:0]  nv_sre,
  output logic             ready_q,
  output logic             rsp_valid_q,
  output logic [15:0]      rsp_data_q,
  output logic [7:0]       stb_q,
  output logic             psc_q,
  output logic [7:0]       ese_q,
  output logic [7:0]       sre_q
);
  typedef struct packed {
    logic        ready;
    logic [15:0] ques_cond;
    logic [15:0] ques_event;
    logic [15:0] ques_en;
    logic [15:0] oper_cond;
    logic [15:0] oper_event;
    logic [15:0] oper_en;
    logic [7:0]  esr;
    logic [7:0]  ese;
    logic [7:0]  sre;
    logic [7:0]  stb;
    logic        psc;
    logic        rsp_valid;
    logic [15:0] rsp_data;
  } state_s;

  state_s              s_q;
  state_s              s_d;
  status_pkg::cmd_e    cmd;
  logic                take;
  logic                clr_ques;
  logic                clr_oper;
  logic                clr_esr;
  logic [15:0]         ques_set;
  logic [15:0]         oper_set;
  logic [7:0]          esr_set;
  logic [7:0]          stb_next;

  errq_if eq ();

  error_queue u_error_queue (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .q       (eq.queue)
  );

  assign cmd          = status_pkg::cmd_e'(cmd_code);
  assign take         = cmd_valid && s_q.ready;
  assign eq.push      = err_push;
  assign eq.push_code = err_code;
  assign eq.pop       = take && (cmd == status_pkg::CMD_ERR_Q);

  assign ready_q     = s_q.ready;
  assign rsp_valid_q = s_q.rsp_valid;
  assign rsp_data_q  = s_q.rsp_data;
  assign stb_q       = s_q.stb;
  assign psc_q       = s_q.psc;
  assign ese_q       = s_q.ese;
  assign sre_q       = s_q.sre;

  always_comb
  begin
    s_d         = s_q;
    s_d.rsp_valid = 1'b0;
    clr_ques    = 1'b0;
    clr_oper    = 1'b0;
    clr_esr     = 1'b0;
    esr_set     = status_pkg::BYTE_RESET;
    // Power-on: the enables that follow the flag come back from non-volatile storage unless it says clear
    if (!s_q.ready)
    begin
      s_d.ready = 1'b1;
      s_d.psc   = nv_psc;                                                  // [R15]
      s_d.ese   = nv_psc ? status_pkg::BYTE_RESET : nv_ese;                // [R15]
      s_d.sre   = nv_psc ? status_pkg::BYTE_RESET : nv_sre;                // [R15]
      esr_set[status_pkg::ESR_PON_BIT] = 1'b1;
    end
    if (meas_done)
    begin
      s_d.ques_cond = status_pkg::REG_RESET;
      s_d.ques_cond[status_pkg::QUES_DCV_BIT]  = ovld_dcv;                 // [R16]
      s_d.ques_cond[status_pkg::QUES_TEMP_BIT] = ovld_temp;                // [R16]
      s_d.ques_cond[status_pkg::QUES_OHMS_BIT] = ovld_ohms;                // [R16]
      s_d.oper_cond = status_pkg::REG_RESET;
      s_d.oper_cond[status_pkg::OPER_SETTLED_BIT] = filter_enabled && filter_settled; // [R4] [R5]
      esr_set[status_pkg::ESR_DEV_BIT] = ovld_dcv || ovld_temp || ovld_ohms;
    end
    // Positive transitions only, so the event bit means the filter ever settled
    ques_set = s_d.ques_cond & ~s_q.ques_cond;
    oper_set = s_d.oper_cond & ~s_q.oper_cond;                             // [R3] [R5]
    esr_set[status_pkg::ESR_QUERY_BIT] = err_query;
    esr_set[status_pkg::ESR_DEV_BIT]   = esr_set[status_pkg::ESR_DEV_BIT] || err_device;
    esr_set[status_pkg::ESR_EXEC_BIT]  = err_exec;
    esr_set[status_pkg::ESR_CMD_BIT]   = err_command;
    if (take)
    begin
      // Commands run one per cycle in arrival order, so all earlier ones are complete here
      case (cmd)
        status_pkg::CMD_CLS:
        begin
          clr_ques = 1'b1;                                                 // [R1] [R12]
          clr_oper = 1'b1;                                                 // [R6] [R12]
          clr_esr  = 1'b1;                                                 // [R12]
        end
        status_pkg::CMD_STAT_PRESET:
        begin
          s_d.ques_en = status_pkg::REG_RESET;                             // [R2] [R11]
          s_d.oper_en = status_pkg::REG_RESET;                             // [R7] [R11]
        end
        status_pkg::CMD_QUES_COND_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = s_q.ques_cond;                                   // [R9]
        end
        status_pkg::CMD_QUES_EVENT_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = s_q.ques_event;                                  // [R9]
          clr_ques      = 1'b1;                                            // [R1]
        end
        status_pkg::CMD_QUES_EN_W:
          s_d.ques_en = cmd_data;                                          // [R2] [R10]
        status_pkg::CMD_QUES_EN_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = s_q.ques_en;                                     // [R9]
        end
        status_pkg::CMD_OPER_COND_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = s_q.oper_cond;                                   // [R9]
        end
        status_pkg::CMD_OPER_EVENT_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = s_q.oper_event;                                  // [R9]
          clr_oper      = 1'b1;                                            // [R6]
        end
        status_pkg::CMD_OPER_EN_W:
          s_d.oper_en = cmd_data;                                          // [R7] [R10]
        status_pkg::CMD_OPER_EN_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = s_q.oper_en;                                     // [R9]
        end
        status_pkg::CMD_ESE_W:
          s_d.ese = cmd_data[7:0];                                         // [R10]
        status_pkg::CMD_ESE_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = {8'h00, s_q.ese};                                // [R9]
        end
        status_pkg::CMD_ESR_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = {8'h00, s_q.esr};                                // [R9]
          clr_esr       = 1'b1;
        end
        status_pkg::CMD_OPC:
          esr_set[status_pkg::ESR_OPC_BIT] = 1'b1;                         // [R13]
        status_pkg::CMD_OPC_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = status_pkg::RESP_ONE;                            // [R14]
        end
        status_pkg::CMD_PSC_W:
          s_d.psc = cmd_data != 16'h0000;                                  // [R15]
        status_pkg::CMD_PSC_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = {15'h0000, s_q.psc};                             // [R15]
        end
        status_pkg::CMD_SRE_W:
          s_d.sre = cmd_data[7:0];                                         // [R10]
        status_pkg::CMD_SRE_Q:
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = {8'h00, s_q.sre};                                // [R9]
        end
        status_pkg::CMD_ERR_Q:
        begin
          // An empty queue answers 0, the no-error code
          s_d.rsp_valid = 1'b1;
          s_d.rsp_data  = eq.empty ? status_pkg::REG_RESET : eq.head;      // [R8]
        end
        default:
          s_d.rsp_valid = 1'b0;
      endcase
    end
    // Set wins over clear so an event in the clearing cycle is kept
    s_d.ques_event = (clr_ques ? status_pkg::REG_RESET : s_q.ques_event) | ques_set;   // [R1]
    s_d.oper_event = (clr_oper ? status_pkg::REG_RESET : s_q.oper_event) | oper_set;   // [R3] [R6]
    s_d.esr        = (clr_esr ? status_pkg::BYTE_RESET : s_q.esr) | esr_set;           // [R12] [R13]
    stb_next = status_pkg::BYTE_RESET;
    stb_next[status_pkg::STB_ERRQ_BIT] = !eq.empty;
    stb_next[status_pkg::STB_QUES_BIT] = |(s_q.ques_event & s_q.ques_en);  // [R17]
    stb_next[status_pkg::STB_ESR_BIT]  = |(s_q.esr & s_q.ese);             // [R17]
    stb_next[status_pkg::STB_OPER_BIT] = |(s_q.oper_event & s_q.oper_en);  // [R17]
    stb_next[status_pkg::STB_RQS_BIT]  = |(stb_next & s_q.sre);            // [R17]
    s_d.stb = stb_next;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic [1:0] sum_w;
  logic       rqs_w;
  assign sum_w = {|(s_q.oper_event & s_q.oper_en), |(s_q.ques_event & s_q.ques_en)};
  assign rqs_w = !eq.empty && s_q.sre[status_pkg::STB_ERRQ_BIT];

  property p_ques_read_clr;
    (take && cmd == status_pkg::CMD_QUES_EVENT_Q && !meas_done) |=> (s_q.ques_event == 16'h0000);
  endproperty
  a_ques_read_clr: assert property (p_ques_read_clr) else $error("questionable event not cleared"); // [R1]

  property p_oper_read_clr;
    (take && cmd == status_pkg::CMD_OPER_EVENT_Q && !meas_done) |=> (s_q.oper_event == 16'h0000);
  endproperty
  a_oper_read_clr: assert property (p_oper_read_clr) else $error("operational event not cleared"); // [R6]

  property p_preset;
    (take && cmd == status_pkg::CMD_STAT_PRESET) |=> (s_q.ques_en == 16'h0000) && (s_q.oper_en == 16'h0000)
      && $stable(s_q.ese) && $stable(s_q.sre);
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not clear enables alone"); // [R11]

  property p_ques_en_write;
    (take && cmd == status_pkg::CMD_QUES_EN_W) |=> (s_q.ques_en == $past(cmd_data));
  endproperty
  a_ques_en_write: assert property (p_ques_en_write) else $error("questionable enable not stored"); // [R2]

  property p_oper_en_write;
    (take && cmd == status_pkg::CMD_OPER_EN_W) |=> (s_q.oper_en == $past(cmd_data));
  endproperty
  a_oper_en_write: assert property (p_oper_en_write) else $error("operational enable not stored"); // [R7]

  property p_oper_latch;
    (s_q.ready && meas_done && filter_enabled && filter_settled && !s_q.oper_cond[8])
      |=> s_q.oper_event[8] ##1 (s_q.oper_event[8] || $past(take));
  endproperty
  a_oper_latch: assert property (p_oper_latch) else $error("settle not latched"); // [R3]

  property p_oper_unused;
    (s_q.oper_cond[15:9] == 7'h00) && (s_q.oper_cond[7:0] == 8'h00) && (s_q.oper_event[7:0] == 8'h00);
  endproperty
  a_oper_unused: assert property (p_oper_unused) else $error("unused operational bit set"); // [R4]

  property p_ques_unused;
    (s_q.ques_cond & 16'hFDEE) == 16'h0000;
  endproperty
  a_ques_unused: assert property (p_ques_unused) else $error("unused questionable bit set"); // [R16]

  property p_cls;
    (take && cmd == status_pkg::CMD_CLS && !meas_done && !err_query && !err_device && !err_exec && !err_command)
      |=> (s_q.esr == 8'h00) && (s_q.ques_event == 16'h0000) && (s_q.oper_event == 16'h0000)
      ##1 ({s_q.stb[7], s_q.stb[5:3]} == 4'h0) && (s_q.stb[6] == $past(rqs_w));
  endproperty
  a_cls: assert property (p_cls) else $error("clear-status left state"); // [R12]

  property p_opc;
    (take && cmd == status_pkg::CMD_OPC) |=> s_q.esr[0];
  endproperty
  a_opc: assert property (p_opc) else $error("operation complete bit not set"); // [R13]

  property p_opc_q;
    (take && cmd == status_pkg::CMD_OPC_Q) |=> s_q.rsp_valid && (s_q.rsp_data == 16'h0001);
  endproperty
  a_opc_q: assert property (p_opc_q) else $error("operation complete query wrong"); // [R14]

  property p_psc_q;
    (take && cmd == status_pkg::CMD_PSC_Q) |=> s_q.rsp_valid && (s_q.rsp_data == {15'h0000, $past(s_q.psc)});
  endproperty
  a_psc_q: assert property (p_psc_q) else $error("power-on clear query wrong"); // [R15]

  property p_stb_sum;
    s_q.ready |=> ({s_q.stb[7], s_q.stb[3]} == $past(sum_w));
  endproperty
  a_stb_sum: assert property (p_stb_sum) else $error("status byte summary wrong"); // [R17]

  property p_query_answer;
    (take && cmd == status_pkg::CMD_OPER_COND_Q) |=> s_q.rsp_valid && (s_q.rsp_data == $past(s_q.oper_cond));
  endproperty
  a_query_answer: assert property (p_query_answer) else $error("condition query wrong"); // [R9]

  c_settle: cover property (meas_done && filter_enabled && filter_settled ##1 s_q.oper_event[8]);
  c_err_read: cover property (take && cmd == status_pkg::CMD_ERR_Q && !eq.empty);
  c_cls_set: cover property (take && cmd == status_pkg::CMD_CLS && meas_done && ovld_dcv);
endmodule

// ===== verification/status_host_model.sv
// Controller-side model that sends status commands to the register set
`timescale 1ns/1ps
module status_host_model (
  input  wire logic        mclk,
  input  wire logic        ready_q,
  output logic             cmd_valid,
  output logic [4:0]       cmd_code,
  output logic [15:0]      cmd_data
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 5'h00;
    cmd_data  = 16'h0000;
  end

  // Changes only at the falling edge, so each request is held across exactly one taking edge
  task automatic issue(input status_pkg::cmd_e c, input logic [15:0] d);
    @(negedge mclk);
    while (ready_q !== 1'b1)
      @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code  = c;
    cmd_data  = d;
  endtask

  // Released data is inverted rather than held, so a stale word is never mistaken for a fresh one
  task automatic idle();
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_data  = ~cmd_data;
  endtask
endmodule

// ===== verification/status_reporting_registers_test.sv
// Self-checking bench for the status-reporting register set
`timescale 1ns/1ps
module status_reporting_registers_test;
  logic        mclk           = 1'b0;
  logic        sys_rst        = 1'b1;
  logic        meas_done      = 1'b0;
  logic        filter_enabled = 1'b0;
  logic        filter_settled = 1'b0;
  logic [2:0]  ovld           = 3'h0;
  logic        err_push       = 1'b0;
  logic [15:0] err_code       = 16'h0000;
  logic [3:0]  err_flags      = 4'h0;
  logic        nv_psc         = 1'b1;
  logic [7:0]  nv_ese         = 8'h00;
  logic [7:0]  nv_sre         = 8'h00;
  wire logic        cmd_valid;
  wire logic [4:0]  cmd_code;
  wire logic [15:0] cmd_data;
  logic        ready_q;
  logic        rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic [7:0]  stb_q;
  logic        psc_q;
  logic [7:0]  ese_q;
  logic [7:0]  sre_q;
  integer      seed = 32'h893DB806;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [15:0] exp_q[$];
  logic [15:0] codes[$];
  logic [15:0] want;
  logic [15:0] prev;

  always #10 mclk = ~mclk;

  status_host_model host_u (.mclk(mclk), .ready_q(ready_q), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data));

  status_regs dut_u (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data), .meas_done(meas_done), .filter_enabled(filter_enabled), .filter_settled(filter_settled),
    .ovld_dcv(ovld[0]), .ovld_temp(ovld[1]), .ovld_ohms(ovld[2]), .err_query(err_flags[0]),
    .err_device(err_flags[1]), .err_exec(err_flags[2]), .err_command(err_flags[3]), .err_push(err_push),
    .err_code(err_code), .nv_psc(nv_psc),
    .nv_ese(nv_ese), .nv_sre(nv_sre), .ready_q(ready_q), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .stb_q(stb_q), .psc_q(psc_q), .ese_q(ese_q), .sre_q(sre_q));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic ask(input status_pkg::cmd_e c, input logic [15:0] exp);
    exp_q.push_back(exp);
    host_u.issue(c, 16'h0000);
  endtask

  task automatic meas(input logic fe, input logic fs, input logic [2:0] ov);
    host_u.idle();
    meas_done      = 1'b1;
    filter_enabled = fe;
    filter_settled = fs;
    ovld           = ov;
    @(negedge mclk);
    meas_done = 1'b0;
  endtask

  // Status byte lags register state by a cycle, so let the pipeline drain first
  task automatic settle();
    host_u.idle();
    repeat (3) @(negedge mclk);
  endtask

  task automatic power_up(input logic psc);
    @(negedge mclk);
    sys_rst = 1'b1;
    nv_psc  = psc;
    nv_ese  = 8'($random(seed));
    nv_sre  = 8'($random(seed));
    repeat (6) @(negedge mclk);
    check(16'(ready_q), 16'h0000, "ready during reset");
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    check(16'(ready_q), 16'h0001, "ready after reset");
  endtask

  always @(posedge mclk)
  begin
    #1;
    if (rsp_valid_q === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(rsp_data_q, ~rsp_data_q, "unrequested answer");
      else
        check(rsp_data_q, exp_q.pop_front(), "query answer");
    end
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("wrong value at %0t: run did not finish in time", $time);
      summarize();
    end
  end

  initial
  begin
    power_up(1'b1);
    check(16'(psc_q), 16'h0001, "psc after power-on");
    check({ese_q, sre_q}, 16'h0000, "masks cleared at power-on");
    ask(status_pkg::CMD_PSC_Q, 16'h0001);
    ask(status_pkg::CMD_ESR_Q, 16'h0080);
    ask(status_pkg::CMD_ESR_Q, 16'h0000);
    host_u.issue(status_pkg::CMD_OPC, 16'h0000);
    ask(status_pkg::CMD_ESR_Q, 16'h0001);
    ask(status_pkg::CMD_OPC_Q, 16'h0001);
    $display("done: power-on and completion");
    meas(1'b1, 1'b1, 3'h0);
    ask(status_pkg::CMD_OPER_COND_Q, 16'h0100);
    meas(1'b0, 1'b1, 3'h0);
    ask(status_pkg::CMD_OPER_COND_Q, 16'h0000);
    ask(status_pkg::CMD_OPER_EVENT_Q, 16'h0100);
    ask(status_pkg::CMD_OPER_EVENT_Q, 16'h0000);
    $display("done: filter settled reporting");
    prev = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      meas(1'b0, 1'b0, i[2:0]);
      want = {6'h00, i[2], 4'h0, i[1], 3'h0, i[0]};
      ask(status_pkg::CMD_QUES_COND_Q, want);
      ask(status_pkg::CMD_QUES_EVENT_Q, want & ~prev);
      prev = want;
    end
    meas(1'b0, 1'b0, 3'h0);
    meas(1'b1, 1'b1, 3'h7);
    host_u.issue(status_pkg::CMD_QUES_EN_W, 16'h0211);
    host_u.issue(status_pkg::CMD_ESE_W, 16'h0008);
    host_u.issue(status_pkg::CMD_OPER_EN_W, 16'h0100);
    host_u.issue(status_pkg::CMD_SRE_W, 16'h0080);
    ask(status_pkg::CMD_QUES_EN_Q, 16'h0211);
    ask(status_pkg::CMD_SRE_Q, 16'h0080);
    settle();
    check(16'(stb_q & 8'hE8), 16'h00E8, "summary bits");
    host_u.issue(status_pkg::CMD_STAT_PRESET, 16'h0000);
    ask(status_pkg::CMD_QUES_EN_Q, 16'h0000);
    ask(status_pkg::CMD_OPER_EN_Q, 16'h0000);
    ask(status_pkg::CMD_ESE_Q, 16'h0008);
    ask(status_pkg::CMD_SRE_Q, 16'h0080);
    host_u.issue(status_pkg::CMD_CLS, 16'h0000);
    ask(status_pkg::CMD_QUES_EVENT_Q, 16'h0000);
    ask(status_pkg::CMD_OPER_EVENT_Q, 16'h0000);
    ask(status_pkg::CMD_ESR_Q, 16'h0000);
    settle();
    check(16'(stb_q), 16'h0000, "status byte after clear");
    host_u.issue(status_pkg::CMD_QUES_EN_W, 16'h0010);
    host_u.issue(status_pkg::CMD_QUES_EN_W, 16'h0000);
    ask(status_pkg::CMD_QUES_EN_Q, 16'h0000);
    $display("done: enables, preset and clear");
    host_u.idle();
    for (int i = 0; i < 21; i++)
    begin
      @(negedge mclk);
      err_push = 1'b1;
      err_code = 16'($random(seed));
      if (i < 20)
        codes.push_back(err_code);
    end
    @(negedge mclk);
    err_push = 1'b0;
    settle();
    check(16'(stb_q[2]), 16'h0001, "queue pending bit");
    for (int i = 0; i < 20; i++)
      ask(status_pkg::CMD_ERR_Q, codes[i]);
    ask(status_pkg::CMD_ERR_Q, 16'h0000);
    settle();
    check(16'(stb_q[2]), 16'h0000, "queue pending bit");
    $display("done: error queue");
    @(negedge mclk);
    err_flags = 4'hF;
    @(negedge mclk);
    err_flags = 4'h0;
    ask(status_pkg::CMD_ESR_Q, 16'h003C);
    host_u.issue(status_pkg::CMD_OPER_EN_W, 16'h0100);
    host_u.issue(status_pkg::CMD_PSC_W, 16'h0000);
    host_u.idle();
    check(16'(psc_q), 16'h0000, "psc after write");
    power_up(1'b0);
    check({ese_q, sre_q}, {nv_ese, nv_sre}, "masks kept at power-on");
    ask(status_pkg::CMD_PSC_Q, 16'h0000);
    ask(status_pkg::CMD_SRE_Q, {8'h00, nv_sre});
    ask(status_pkg::CMD_OPER_EN_Q, 16'h0000);
    ask(status_pkg::CMD_QUES_EN_Q, 16'h0000);
    settle();
    $display("done: power-on retention");
    check(16'(exp_q.size()), 16'h0000, "answers outstanding");
    summarize();
  end
endmodule
